/* rtl/x21_ta_defines.svh */
// constants for the x.21 terminal adaptor alignment and cause mapping
`ifndef X21_TA_DEFINES_SVH
`define X21_TA_DEFINES_SVH

// ************************************************************
// alignment and buffering
// ************************************************************
`define FA_PATTERN      8'hbb
`define RX_FIFO_DEPTH   16
`define RX_FIFO_WIDTH   2

// ************************************************************
// reported x.21 states
// ************************************************************
`define X21_ST_NONE      5'h00
`define X21_ST_CPS       5'h07
`define X21_ST_CONN_PROG 5'h0b
`define X21_ST_READY     5'h0c
`define X21_ST_DATA      5'h0d

// ************************************************************
// clearing causes used for refusal
// ************************************************************
`define CAUSE_USER_BUSY  7'h11
`define CAUSE_REJECTED   7'h15
`define CAUSE_DEST_OOO   7'h1b

// ************************************************************
// call progress codes
// ************************************************************
`define CPS_NO_CONN      7'h14
`define CPS_BUSY         7'h15
`define CPS_SEL_PROC_ERR 7'h16
`define CPS_SEL_TX_ERR   7'h17
`define CPS_CHANGED_NUM  7'h2a
`define CPS_NOT_OBTAIN   7'h2b
`define CPS_OUT_OF_ORDER 7'h2c
`define CPS_CTRL_NR      7'h2d
`define CPS_UNCTRL_NR    7'h2e
`define CPS_INV_FACILITY 7'h30
`define CPS_INCOMPAT     7'h34
`define CPS_CONGESTION   7'h3d
`define CPS_ROA_OOO      7'h48

`endif

/* rtl/x21_ta_pkg.sv */
// types shared by the terminal adaptor design
package x21_ta_pkg;

  typedef struct packed {
    logic data;
    logic status;
  } b_bit_t;

  typedef struct packed {
    logic       valid;
    logic       has_cause;
    logic [6:0] cause;
  } cause_msg_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] code;
  } cps_t;

  typedef enum logic [1:0] {
    REJ_CTRL_NOT_READY,
    REJ_UNCTRL_NOT_READY,
    REJ_BUSY
  } reject_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_WAIT_SCAN,
    ST_ALT_HOLD,
    ST_THROUGH,
    ST_MAP,
    ST_CPS,
    ST_CLEAR
  } ta_state_t;

endpackage

/* rtl/stream_fifo.sv */
// flip-flop fifo with valid and ready on both sides
`include "x21_ta_defines.svh"
module stream_fifo #(
  parameter int WIDTH = `RX_FIFO_WIDTH,
  parameter int DEPTH = `RX_FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push       = i_in_valid && o_in_ready;
  assign pop        = i_out_ready && o_out_valid;
  assign o_out_data = mem_reg[rd_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (!push && pop) begin
      count_next = count_reg - 1'b1;
    end
  end

  // flags registered so ready toward the source is a clean flop
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_reg   <= '0;
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      count_reg   <= count_next;
      o_in_ready  <= count_next != (AW+1)'(DEPTH);
      o_out_valid <= count_next != '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end
endmodule

/* rtl/cause_to_progress.sv */
// registered lookup from clearing cause to call progress code
`include "x21_ta_defines.svh"
module cause_to_progress (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_valid,
  input  wire logic [6:0] i_cause,
  output logic            o_valid,
  output logic            o_has_code,
  output logic [6:0]      o_code
);
  // result is {has_code, code}
  function automatic logic [7:0] map_cause(input logic [6:0] c);
    unique case (c)
      7'h01, 7'h03, 7'h06, 7'h51, 7'h52, 7'h58, 7'h66: map_cause = {1'b1, `CPS_NOT_OBTAIN};
      7'h10, 7'h1f, 7'h31:                             map_cause = {1'b0, 7'h00};
      7'h12, 7'h13, 7'h22, 7'h2c, 7'h3f:               map_cause = {1'b1, `CPS_NO_CONN};
      `CAUSE_USER_BUSY:                                map_cause = {1'b1, `CPS_BUSY};
      `CAUSE_REJECTED:                                 map_cause = {1'b1, `CPS_CTRL_NR};
      7'h16:                                           map_cause = {1'b1, `CPS_CHANGED_NUM};
      `CAUSE_DEST_OOO:                                 map_cause = {1'b1, `CPS_UNCTRL_NR};
      7'h1c, 7'h60, 7'h61, 7'h62, 7'h63, 7'h65:        map_cause = {1'b1, `CPS_SEL_PROC_ERR};
      7'h6f:                                           map_cause = {1'b1, `CPS_CHANGED_NUM};
      7'h5f, 7'h64:                                    map_cause = {1'b1, `CPS_SEL_TX_ERR};
      7'h26, 7'h29:                                    map_cause = {1'b1, `CPS_OUT_OF_ORDER};
      7'h7f:                                           map_cause = {1'b1, `CPS_ROA_OOO};
      7'h2a, 7'h2f, 7'h3a:                             map_cause = {1'b1, `CPS_CONGESTION};
      7'h39:                                           map_cause = {1'b1, `CPS_INCOMPAT};
      7'h41, 7'h42, 7'h4f:                             map_cause = {1'b1, `CPS_INV_FACILITY};
      default:                                         map_cause = {1'b0, 7'h00};
    endcase
  endfunction

  logic [7:0] mapped;

  assign mapped = map_cause(i_cause);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_valid    <= 1'b0;
      o_has_code <= 1'b0;
      o_code     <= 7'h00;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        o_has_code <= mapped[7];
        o_code     <= mapped[6:0];
      end
    end
  end
endmodule

/* rtl/x21_terminal_adaptor.sv */
// ready-for-data alignment and clearing cause translation for a single-rate adaptor
`include "x21_ta_defines.svh"
module x21_terminal_adaptor (
  input  wire logic                     i_clk,
  input  wire logic                     i_arst_n,
  input  wire logic                     i_dte_t,
  input  wire logic                     i_dte_c,
  input  wire logic                     i_bit_tick,
  input  wire x21_ta_pkg::b_bit_t       i_b_rx,
  input  wire logic                     i_b_rx_valid,
  output logic                          o_b_rx_ready,
  output x21_ta_pkg::b_bit_t            o_b_tx,
  output logic                          o_b_tx_valid,
  output logic                          o_dte_r,
  output logic                          o_dte_i,
  input  wire logic                     i_call_connected,
  input  wire logic                     i_info_pending,
  input  wire logic                     i_alt_switch,
  input  wire x21_ta_pkg::cause_msg_t   i_disc,
  input  wire logic                     i_offer_reject,
  input  wire x21_ta_pkg::reject_kind_t i_offer_kind,
  output x21_ta_pkg::cause_msg_t        o_rel_complete,
  output x21_ta_pkg::cps_t              o_cps,
  output logic [4:0]                    o_x21_state,
  output logic                          o_aligned,
  output logic                          o_through
);

  // ************************************************************
  // dte pin synchronisers
  // ************************************************************
  logic [1:0] t_sync_reg;
  logic [1:0] c_sync_reg;
  logic       dte_t;
  logic       dte_c;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      t_sync_reg <= 2'h3;
      c_sync_reg <= 2'h0;
    end else begin
      t_sync_reg <= {t_sync_reg[0], i_dte_t};
      c_sync_reg <= {c_sync_reg[0], i_dte_c};
    end
  end

  assign dte_t = t_sync_reg[1];
  assign dte_c = c_sync_reg[1];

  // ************************************************************
  // receive buffer and alignment search
  // ************************************************************
  x21_ta_pkg::ta_state_t state_reg;
  x21_ta_pkg::ta_state_t state_next;
  x21_ta_pkg::b_bit_t    head;
  logic                  head_valid;
  logic                  head_take;
  logic                  rx_push;
  logic                  linked;
  logic [7:0]            fa_shift_reg;
  logic [7:0]            fa_shift_next;

  assign rx_push       = i_b_rx_valid && o_b_rx_ready;
  assign fa_shift_next = {fa_shift_reg[6:0], i_b_rx.data};
  // before the link is through, stale bits are dropped so the search never stalls
  assign linked        = (state_reg == x21_ta_pkg::ST_THROUGH) || (state_reg == x21_ta_pkg::ST_ALT_HOLD);
  assign head_take     = linked ? i_bit_tick : 1'b1;

  stream_fifo #(
    .WIDTH (`RX_FIFO_WIDTH),
    .DEPTH (`RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (i_b_rx_valid),
    .o_in_ready  (o_b_rx_ready),
    .i_in_data   (i_b_rx),
    .o_out_valid (head_valid),
    .i_out_ready (head_take),
    .o_out_data  (head)
  );

  // the shift register takes every accepted bit whatever the state, but a match only sets o_aligned outside idle and clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fa_shift_reg <= 8'h00;
    end else if (rx_push) begin
      fa_shift_reg <= fa_shift_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_aligned <= 1'b0;
    end else if (state_reg == x21_ta_pkg::ST_IDLE || state_reg == x21_ta_pkg::ST_CLEAR) begin
      o_aligned <= 1'b0;
    end else if (rx_push && fa_shift_next == `FA_PATTERN) begin
      o_aligned <= 1'b1;
    end
  end

  // ************************************************************
  // cause translation
  // ************************************************************
  logic       map_start;
  logic       map_valid;
  logic       map_has_code;
  logic [6:0] map_code;
  logic       reached_reg;
  logic       early_disc;

  // mapping only applies while state 11 or 12 has not been seen
  assign early_disc = i_disc.valid && i_disc.has_cause && !reached_reg && state_reg != x21_ta_pkg::ST_CLEAR;
  assign map_start  = early_disc && state_reg != x21_ta_pkg::ST_MAP && state_reg != x21_ta_pkg::ST_CPS;

  cause_to_progress u_map (
    .i_clk      (i_clk),
    .i_arst_n   (i_arst_n),
    .i_valid    (map_start),
    .i_cause    (i_disc.cause),
    .o_valid    (map_valid),
    .o_has_code (map_has_code),
    .o_code     (map_code)
  );

  // ************************************************************
  // call phase state machine
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      x21_ta_pkg::ST_IDLE: begin
        if (i_call_connected) begin
          state_next = x21_ta_pkg::ST_SEARCH;
        end
      end
      x21_ta_pkg::ST_SEARCH: begin
        if (o_aligned && !i_info_pending) begin
          state_next = x21_ta_pkg::ST_WAIT_SCAN;
        end
      end
      x21_ta_pkg::ST_WAIT_SCAN: begin
        if (i_bit_tick) begin
          state_next = i_alt_switch ? x21_ta_pkg::ST_ALT_HOLD : x21_ta_pkg::ST_THROUGH;
        end
      end
      x21_ta_pkg::ST_ALT_HOLD: begin
        if (i_bit_tick && o_x21_state == `X21_ST_READY) begin
          state_next = x21_ta_pkg::ST_THROUGH;
        end
      end
      x21_ta_pkg::ST_THROUGH: begin
        state_next = x21_ta_pkg::ST_THROUGH;
      end
      x21_ta_pkg::ST_MAP: begin
        if (map_valid) begin
          state_next = map_has_code ? x21_ta_pkg::ST_CPS : x21_ta_pkg::ST_CLEAR;
        end
      end
      x21_ta_pkg::ST_CPS: begin
        state_next = x21_ta_pkg::ST_CLEAR;
      end
      x21_ta_pkg::ST_CLEAR: begin
        if (!dte_t && !dte_c) begin
          state_next = x21_ta_pkg::ST_IDLE;
        end
      end
    endcase
    if (map_start) begin
      state_next = x21_ta_pkg::ST_MAP;
    end else if (i_disc.valid && !early_disc) begin
      state_next = x21_ta_pkg::ST_CLEAR;
    end else if (!i_call_connected && state_reg != x21_ta_pkg::ST_MAP
                 && state_reg != x21_ta_pkg::ST_CPS && state_reg != x21_ta_pkg::ST_CLEAR) begin
      state_next = x21_ta_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= x21_ta_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // far end status and reported state
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_x21_state <= `X21_ST_NONE;
      reached_reg <= 1'b0;
    end else if (state_next == x21_ta_pkg::ST_IDLE || state_next == x21_ta_pkg::ST_CLEAR) begin
      o_x21_state <= `X21_ST_NONE;
      reached_reg <= 1'b0;
    end else if (state_next == x21_ta_pkg::ST_CPS) begin
      o_x21_state <= `X21_ST_CPS;
    end else if (state_reg == x21_ta_pkg::ST_ALT_HOLD && state_next == x21_ta_pkg::ST_THROUGH) begin
      o_x21_state <= `X21_ST_DATA;
    end else if (linked && head_take && head_valid && head.data && o_x21_state != `X21_ST_DATA) begin
      o_x21_state <= head.status ? `X21_ST_READY : `X21_ST_CONN_PROG;
      reached_reg <= 1'b1;
    end
  end

  // ************************************************************
  // line drivers toward dte and distant end
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dte_r <= 1'b1;
      o_dte_i <= 1'b0;
    end else if (state_reg == x21_ta_pkg::ST_CLEAR) begin
      o_dte_r <= 1'b0;
      o_dte_i <= 1'b0;
    end else if (state_reg == x21_ta_pkg::ST_THROUGH) begin
      if (head_take && head_valid) begin
        o_dte_r <= head.data;
        o_dte_i <= head.status;
      end
    end else if (state_reg == x21_ta_pkg::ST_ALT_HOLD) begin
      // dte sees 1,on in the same cycle that state 12 is reported, not one later
      o_dte_r <= 1'b1;
      if (head_take && head_valid && head.data) begin
        o_dte_i <= head.status;
      end else begin
        o_dte_i <= o_x21_state == `X21_ST_READY;
      end
    end else begin
      o_dte_r <= 1'b1;
      o_dte_i <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_b_tx       <= '{data: 1'b1, status: 1'b0};
      o_b_tx_valid <= 1'b0;
    end else begin
      o_b_tx_valid <= i_bit_tick;
      if (i_bit_tick) begin
        if (state_reg == x21_ta_pkg::ST_ALT_HOLD) begin
          o_b_tx <= '{data: 1'b1, status: 1'b1};
        end else if (state_reg == x21_ta_pkg::ST_THROUGH || state_next == x21_ta_pkg::ST_THROUGH) begin
          o_b_tx <= '{data: dte_t, status: dte_c};
        end else begin
          o_b_tx <= '{data: 1'b1, status: 1'b0};
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_through <= 1'b0;
    end else begin
      o_through <= state_next == x21_ta_pkg::ST_THROUGH || state_next == x21_ta_pkg::ST_ALT_HOLD;
    end
  end

  // ************************************************************
  // call progress and offered call refusal
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cps <= '0;
    end else if (state_reg == x21_ta_pkg::ST_MAP && map_valid && map_has_code && !map_start) begin
      o_cps <= '{valid: 1'b1, code: map_code};
    end else begin
      o_cps.valid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rel_complete <= '0;
    end else if (i_offer_reject) begin
      o_rel_complete.valid     <= 1'b1;
      o_rel_complete.has_cause <= 1'b1;
      unique case (i_offer_kind)
        x21_ta_pkg::REJ_CTRL_NOT_READY:   o_rel_complete.cause <= `CAUSE_REJECTED;
        x21_ta_pkg::REJ_UNCTRL_NOT_READY: o_rel_complete.cause <= `CAUSE_DEST_OOO;
        x21_ta_pkg::REJ_BUSY:             o_rel_complete.cause <= `CAUSE_USER_BUSY;
        default:                          o_rel_complete.cause <= `CAUSE_REJECTED;
      endcase
    end else begin
      o_rel_complete.valid <= 1'b0;
    end
  end

endmodule

/* tb/x21_ta_props.sv */
// port assertions for the terminal adaptor
module x21_ta_props (
  input wire logic                     i_clk,
  input wire logic                     i_arst_n,
  input wire logic                     i_dte_t,
  input wire logic                     i_bit_tick,
  input wire x21_ta_pkg::cause_msg_t   i_disc,
  input wire logic                     i_offer_reject,
  input wire x21_ta_pkg::reject_kind_t i_offer_kind,
  input wire x21_ta_pkg::cause_msg_t   o_rel_complete,
  input wire x21_ta_pkg::cps_t         o_cps,
  input wire logic [4:0]               o_x21_state,
  input wire logic                     o_dte_r,
  input wire logic                     o_dte_i,
  input wire logic                     o_aligned,
  input wire logic                     o_through
);
  // ****************
  // checks
  // ****************
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  chk_rel_pulse: assert property (i_offer_reject |=> o_rel_complete.valid)
    else $error("release complete missing");
  chk_rel_busy: assert property (i_offer_reject && i_offer_kind == x21_ta_pkg::REJ_BUSY
    |=> o_rel_complete.cause == 7'h11)
    else $error("busy refusal cause wrong");
  chk_align_first: assert property ($rose(o_through) |-> o_aligned)
    else $error("through without alignment");
  chk_scan_edge: assert property ($rose(o_through) |-> $past(i_bit_tick))
    else $error("through not at scan tick");
  chk_state_ready: assert property ($changed(o_x21_state) && o_x21_state == 5'h0c && o_through
    |-> o_dte_r && o_dte_i)
    else $error("state 12 without 1,on");
  chk_state_conn: assert property ($changed(o_x21_state) && o_x21_state == 5'h0b && o_through
    |-> o_dte_r && !o_dte_i)
    else $error("state 11 without 1,off");
  chk_no_code: assert property (i_disc.valid && i_disc.has_cause && i_disc.cause == 7'h10
    |-> ##2 !o_cps.valid)
    else $error("progress sent for normal clearing");
  chk_cps_state: assert property (o_cps.valid |-> o_x21_state == 5'h07)
    else $error("progress outside state 7");
  chk_cps_delay: assert property (o_cps.valid |-> $past(i_disc.valid, 2))
    else $error("progress without disconnect");
  chk_clear_after: assert property (o_cps.valid && i_dte_t |-> ##2 !o_dte_r && !o_dte_i)
    else $error("no clear after progress");
endmodule

bind x21_terminal_adaptor x21_ta_props x21_ta_props_i (.i_clk, .i_arst_n, .i_dte_t, .i_bit_tick,
  .i_disc, .i_offer_reject, .i_offer_kind, .o_rel_complete, .o_cps, .o_x21_state, .o_dte_r,
  .o_dte_i, .o_aligned, .o_through);

/* tb/far_end_model.sv */
// distant adaptor sending alignment pattern then its status
module far_end_model (
  input wire logic           i_clk,
  input wire logic           i_arst_n,
  input wire logic           i_go,
  input wire logic           i_status,
  input wire logic           i_ready,
  output x21_ta_pkg::b_bit_t o_bit,
  output logic               o_valid
);
  localparam logic [7:0] ALIGN_WORD = 8'hbb;
  logic [3:0] idx_reg;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_reg <= 4'h0;
      o_valid <= 1'b0;
      o_bit <= 2'b01;
    end else if (!i_go) begin
      idx_reg <= 4'h0;
      o_valid <= 1'b0;
      o_bit <= ~o_bit; // line released: never a stale value
    end else if (!o_valid || i_ready) begin
      o_valid <= 1'b1;
      if (idx_reg < 4'h8) begin
        o_bit <= '{data: ALIGN_WORD[3'h7 - idx_reg[2:0]], status: 1'b0};
        idx_reg <= idx_reg + 4'h1;
      end else begin
        o_bit <= {1'b1, i_status};
      end
    end
  end
endmodule

/* tb/tb_call_progress_and_rfd_alignment.sv */
// testbench for the terminal adaptor alignment and cause translation
module tb_call_progress_and_rfd_alignment;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     i_clk = 0, i_arst_n = 0, i_dte_t = 1, i_dte_c = 0, i_bit_tick = 0;
  logic                     i_b_rx_valid, o_b_rx_ready, o_b_tx_valid, o_dte_r, o_dte_i;
  logic                     i_call_connected = 0, i_info_pending = 0, i_alt_switch = 0;
  logic                     i_offer_reject = 0, o_aligned, o_through, far_go = 0, far_status = 1;
  x21_ta_pkg::b_bit_t       i_b_rx, o_b_tx;
  x21_ta_pkg::cause_msg_t   i_disc = '0, o_rel_complete;
  x21_ta_pkg::reject_kind_t i_offer_kind = x21_ta_pkg::REJ_BUSY;
  x21_ta_pkg::cps_t         o_cps;
  logic [4:0]               o_x21_state;
  int                       bad_count = 0, n_tests = 0, tick_cnt = 0, k;
  // cause in upper byte; valid bit and code below, zero means no signal
  logic [15:0] map_tbl [39] = '{16'h01ab, 16'h03ab, 16'h06ab, 16'h1000, 16'h1195, 16'h1294, 16'h1394,
    16'h15ad, 16'h16aa, 16'h1bae, 16'h1c96, 16'h1f00, 16'h2294, 16'h26ac, 16'h29ac, 16'h2abd, 16'h2c94,
    16'h2fbd, 16'h3100, 16'h39b4, 16'h3abd, 16'h3f94, 16'h41b0, 16'h42b0, 16'h4fb0, 16'h51ab, 16'h52ab,
    16'h58ab, 16'h5f97, 16'h6096, 16'h6196, 16'h6296, 16'h6396, 16'h6497, 16'h6596, 16'h66ab, 16'h6faa,
    16'h7fc8, 16'h0200};

  x21_terminal_adaptor x21_terminal_adaptor_i (.i_clk, .i_arst_n, .i_dte_t, .i_dte_c, .i_bit_tick,
    .i_b_rx, .i_b_rx_valid, .o_b_rx_ready, .o_b_tx, .o_b_tx_valid, .o_dte_r, .o_dte_i,
    .i_call_connected, .i_info_pending, .i_alt_switch, .i_disc, .i_offer_reject, .i_offer_kind,
    .o_rel_complete, .o_cps, .o_x21_state, .o_aligned, .o_through);
  far_end_model far_end_model_i (.i_clk, .i_arst_n, .i_go(far_go), .i_status(far_status),
    .i_ready(o_b_rx_ready), .o_bit(i_b_rx), .o_valid(i_b_rx_valid));

  always #5 i_clk = ~i_clk;
  // scan instant every 16 cycles, slow enough to fill the fifo
  always begin
    @(posedge i_clk);
    #1;
    i_bit_tick = (tick_cnt == 15);
    tick_cnt = (tick_cnt + 1) % 16;
  end

  // ****************
  // helpers
  // ****************
  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  task automatic expire(input string what);
    bad_count++;
    $display("unexpected %s: expected done seen timeout", what);
    complete_run();
  endtask
  task automatic finish_clear();
    i_dte_t = 0;
    i_dte_c = 0;
    i_call_connected = 0;
    for (k = 0; o_dte_r !== 1'b1; k++) begin
      if (k > 50) expire("clear end");
      step();
    end
    i_dte_t = 1;
    repeat (4) step();
  endtask
  task automatic disconnect(input logic has, input logic [6:0] cause, input logic [7:0] exp);
    i_disc = {1'b1, has, cause};
    step();
    i_disc = '0;
    step();
    check("progress valid", o_cps.valid, exp[7]);
    if (exp[7]) begin
      check("progress code", o_cps.code, exp[6:0]);
      check("state 7", o_x21_state, 8'h07);
    end
    repeat (2) step();
    check("clear r", o_dte_r, 0);
    finish_clear();
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic s_offer();
    for (int j = 0; j < 3; j++) begin
      i_offer_kind = x21_ta_pkg::reject_kind_t'(j);
      i_offer_reject = 1;
      step();
      check("rel valid", o_rel_complete.valid, 1);
      check("rel has cause", o_rel_complete.has_cause, 1);
      check("rel cause", o_rel_complete.cause, j == 0 ? 8'h15 : j == 1 ? 8'h1b : 8'h11);
    end
    i_offer_reject = 0;
    step();
    check("rel idle", o_rel_complete.valid, 0);
  endtask
  task automatic s_map();
    foreach (map_tbl[j]) disconnect(1'b1, map_tbl[j][14:8], map_tbl[j][7:0]);
  endtask
  task automatic s_align();
    i_dte_c = 1;
    i_info_pending = 1;
    i_call_connected = 1;
    far_status = 1;
    far_go = 1;
    repeat (60) step();
    check("aligned", o_aligned, 1);
    check("held back", o_through, 0);
    i_info_pending = 0;
    for (k = 0; o_b_tx_valid !== 1'b1 || o_through !== 1'b1; k++) begin
      if (k > 100) expire("through");
      step();
    end
    check("dte forward", o_b_tx, 2'b11);
    for (k = 0; o_x21_state !== 5'h0c; k++) begin
      if (k > 1000) expire("state 12");
      step();
    end
    check("ready i", o_dte_i, 1);
    step();
    check("fifo full", o_b_rx_ready, 0);
    far_status = 0;
    for (k = 0; o_x21_state !== 5'h0b; k++) begin
      if (k > 1000) expire("state 11");
      step();
    end
    check("progress i", o_dte_i, 0);
    far_go = 0;
    for (k = 0; o_b_rx_ready !== 1'b1; k++) begin
      if (k > 600) expire("fifo drain");
      step();
    end
    disconnect(1'b1, 7'h11, 8'h00);
  endtask
  task automatic s_alt();
    i_alt_switch = 1;
    i_call_connected = 1;
    far_status = 1;
    far_go = 1;
    for (k = 0; o_b_tx_valid !== 1'b1 || o_through !== 1'b1; k++) begin
      if (k > 300) expire("alt through");
      step();
    end
    check("alt entry tx", o_b_tx, 2'b10);
    repeat (16) step();
    check("alt tick", o_b_tx_valid, 1);
    check("alt tx", o_b_tx, 2'b11);
    for (k = 0; o_x21_state !== 5'h0d; k++) begin
      if (k > 1000) expire("state 13");
      step();
    end
    far_go = 0;
    i_alt_switch = 0;
    disconnect(1'b0, 7'h00, 8'h00);
  endtask

  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    i_arst_n = 1;
    check("reset r", o_dte_r, 1);
    check("reset state", o_x21_state, 8'h00);
    check("reset ready", o_b_rx_ready, 1);
    repeat (3) step();
    s_offer();
    s_map();
    s_align();
    s_alt();
    complete_run();
  end
endmodule
